// *** core/sram_host.sv ***
// Host controller driving the strobes and data pins of an asynchronous SRAM.
`timescale 1ns/1ps
`include "sram_host_consts.svh"
`default_nettype none
module sram_host
#(
	parameter int ADDR_WIDTH = 18,
	parameter int DATA_WIDTH = 16
)
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [ADDR_WIDTH-1:0] req_addr,
	input wire logic [DATA_WIDTH-1:0] req_wdata,
	input wire logic [1:0] req_lanes,
	input wire logic retain_req,
	output logic req_ready,
	output logic rsp_valid,
	output logic [DATA_WIDTH-1:0] rsp_rdata,
	output logic retained,
	output logic [ADDR_WIDTH-1:0] sram_addr,
	output logic sram_select_low,
	output logic sram_select_high,
	output logic write_strobe_n,
	output logic output_strobe_n,
	output logic lower_lane_enable_n,
	output logic upper_lane_enable_n,
	input wire logic [DATA_WIDTH-1:0] data_in,
	output logic [DATA_WIDTH-1:0] data_out,
	output logic data_oe
);
	localparam int HALF = DATA_WIDTH / 2;
	localparam sram_host_pkg::count_t READ_LOAD = 8'(`READ_CYCLES - 1);
	localparam sram_host_pkg::count_t WSET_LOAD =
		8'(`WRITE_CYCLES - `WRITE_SETUP_CYCLES - 1);
	localparam sram_host_pkg::count_t WPUL_LOAD = 8'(`WRITE_SETUP_CYCLES - 1);
	localparam sram_host_pkg::count_t GAP_LOAD = 8'(`RELEASE_CYCLES - 1);
	localparam sram_host_pkg::count_t REC_LOAD = 8'(`RECOVER_CYCLES - 1);

	sram_host_pkg::host_state_e state;
	sram_host_pkg::host_state_e next_state;
	logic [DATA_WIDTH-1:0] din_meta;
	logic [DATA_WIDTH-1:0] din_sync;
	logic [1:0] sample_pipe;
	wire timer_done;
	wire timer_load;
	sram_host_pkg::count_t timer_value;
	wire take_req;
	wire [1:0] lanes_n;

	// Lanes are active low; no lane at all is forced to both lanes.
	assign lanes_n = (req_lanes == 2'b00) ? 2'b00 : ~req_lanes;
	assign take_req = (state == sram_host_pkg::ST_IDLE) && req_valid
		&& req_ready && !retain_req;
	assign timer_load = (state != next_state);

	always_comb
	begin
		next_state = state;
		timer_value = 8'h00;
		unique case (state)
			sram_host_pkg::ST_IDLE:
			begin
				if (retain_req)
					next_state = sram_host_pkg::ST_RETAIN;
				else if (take_req && req_write)
				begin
					next_state = sram_host_pkg::ST_WSET;
					timer_value = WSET_LOAD;
				end
				else if (take_req)
				begin
					next_state = sram_host_pkg::ST_READ;
					timer_value = READ_LOAD;
				end
			end
			sram_host_pkg::ST_READ:
			begin
				if (timer_done)
				begin
					next_state = sram_host_pkg::ST_GAP;
					timer_value = GAP_LOAD;
				end
			end
			sram_host_pkg::ST_WSET:
			begin
				if (timer_done)
				begin
					next_state = sram_host_pkg::ST_WPUL;
					timer_value = WPUL_LOAD;
				end
			end
			sram_host_pkg::ST_WPUL:
			begin
				if (timer_done)
				begin
					next_state = sram_host_pkg::ST_GAP;
					timer_value = GAP_LOAD;
				end
			end
			sram_host_pkg::ST_GAP:
			begin
				if (timer_done)
					next_state = sram_host_pkg::ST_IDLE;
			end
			sram_host_pkg::ST_RETAIN:
			begin
				if (!retain_req)
				begin
					next_state = sram_host_pkg::ST_RECOVER;
					timer_value = REC_LOAD;
				end
			end
			sram_host_pkg::ST_RECOVER:
			begin
				if (timer_done)
					next_state = sram_host_pkg::ST_IDLE;
			end
		endcase
	end

	cycle_timer timer
	(
		.sys_clk(sys_clk),
		.reset(reset),
		.load(timer_load),
		.load_value(timer_value),
		.done(timer_done)
	);

	// The data pins pass two flip-flops before the read word is taken.
	always_ff @(posedge sys_clk)
	begin
		din_meta <= data_in;
		din_sync <= din_meta;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			state <= sram_host_pkg::ST_IDLE;
		else
			state <= next_state;
	end

	// Sampling waits for the access time plus the synchroniser delay.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			sample_pipe <= 2'b00;
		else
			sample_pipe <= {sample_pipe[0], (state == sram_host_pkg::ST_READ)
				&& timer_done};
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
		end
		else
		begin
			rsp_valid <= sample_pipe[1];
			if (sample_pipe[1])
			begin
				rsp_rdata[HALF-1:0] <= lower_lane_enable_n ? '0
					: din_sync[HALF-1:0];
				rsp_rdata[DATA_WIDTH-1:HALF] <= upper_lane_enable_n ? '0
					: din_sync[DATA_WIDTH-1:HALF];
			end
		end
	end

	// Pins: the selects stay active through the read and the whole write,
	// and the write strobe opens only after the selects (no output drive).
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			sram_addr <= '0;
			sram_select_low <= 1'b1;
			sram_select_high <= 1'b0;
			write_strobe_n <= 1'b1;
			output_strobe_n <= 1'b1;
			lower_lane_enable_n <= 1'b1;
			upper_lane_enable_n <= 1'b1;
			data_out <= '0;
			data_oe <= 1'b0;
			req_ready <= 1'b0;
			retained <= 1'b0;
		end
		else
		begin
			req_ready <= (next_state == sram_host_pkg::ST_IDLE) && !retain_req;
			retained <= (next_state == sram_host_pkg::ST_RETAIN);
			if (take_req)
			begin
				sram_addr <= req_addr;
				data_out <= req_wdata;
				lower_lane_enable_n <= lanes_n[0];
				upper_lane_enable_n <= lanes_n[1];
			end
			unique case (next_state)
				sram_host_pkg::ST_READ:
				begin
					sram_select_low <= 1'b0;
					sram_select_high <= 1'b1;
					output_strobe_n <= 1'b0;
					write_strobe_n <= 1'b1;
					data_oe <= 1'b0;
				end
				sram_host_pkg::ST_WSET:
				begin
					sram_select_low <= 1'b0;
					sram_select_high <= 1'b1;
					output_strobe_n <= 1'b1;
					write_strobe_n <= 1'b1;
					data_oe <= 1'b1;
				end
				sram_host_pkg::ST_WPUL:
				begin
					write_strobe_n <= 1'b0;
					data_oe <= 1'b1;
				end
				default:
				begin
					// Deselect ends the access; lanes stay set through the gap.
					sram_select_low <= 1'b1;
					sram_select_high <= 1'b0;
					write_strobe_n <= 1'b1;
					output_strobe_n <= 1'b1;
					data_oe <= 1'b0;
					if (next_state != sram_host_pkg::ST_GAP)
					begin
						lower_lane_enable_n <= 1'b1;
						upper_lane_enable_n <= 1'b1;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// *** common/sram_host_consts.svh ***
// Timing constants and notes for the asynchronous SRAM host controller.
// Notes on behaviour
// - First select active low, second active high, lanes active low; inactive means standby.
// - Host must not drive data against memory output during a write cycle.
// - Write recovery counts from the first strobe, lane or select going inactive.
// - Host holds a valid address at least 60 ns before write end.
// - Host holds both selects active at least 60 ns before write end.
// - Host presents write data at least 30 ns before write end, held to the end.
// - After data retention, host waits one read cycle time before accesses.
`ifndef SRAM_HOST_CONSTS_SVH
`define SRAM_HOST_CONSTS_SVH
`define CLK_PERIOD_NS 10
`define READ_CYCLE_NS 70
`define WRITE_CYCLE_NS 70
`define ACCESS_NS 70
`define WRITE_SETUP_NS 60
`define DATA_SETUP_NS 30
`define RELEASE_NS 30
`define CYC_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYCLES `CYC_UP(`READ_CYCLE_NS)
`define WRITE_CYCLES `CYC_UP(`WRITE_CYCLE_NS)
`define ACCESS_CYCLES `CYC_UP(`ACCESS_NS)
`define WRITE_SETUP_CYCLES `CYC_UP(`WRITE_SETUP_NS)
`define DATA_SETUP_CYCLES `CYC_UP(`DATA_SETUP_NS)
`define RELEASE_CYCLES `CYC_UP(`RELEASE_NS)
`define RECOVER_CYCLES `CYC_UP(`READ_CYCLE_NS)
`endif

// *** common/sram_host_pkg.sv ***
// Types shared by the asynchronous SRAM host controller.
`default_nettype none
package sram_host_pkg;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_READ = 7'h02,
		ST_WSET = 7'h04,
		ST_WPUL = 7'h08,
		ST_GAP = 7'h10,
		ST_RETAIN = 7'h20,
		ST_RECOVER = 7'h40
	} host_state_e;
	typedef logic [7:0] count_t;
endpackage
`default_nettype wire

// *** core/cycle_timer.sv ***
// Down counter that marks the end of a timed phase.
`timescale 1ns/1ps
`default_nettype none
module cycle_timer
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic load,
	input wire sram_host_pkg::count_t load_value,
	output logic done
);
	sram_host_pkg::count_t count;
	wire sram_host_pkg::count_t next_count;

	assign next_count = load ? load_value :
		(count != 8'h00) ? count - 8'h01 : 8'h00;
	// Done ignores the load, so the caller's next-state logic, which
	// drives the load, never loops back through this flag.
	assign done = (count == 8'h00);

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			count <= 8'h00;
		else
			count <= next_count;
	end
endmodule
`default_nettype wire

// *** dv/sram_host_checker.sv ***
// Checker of the pin timing driven by the SRAM host controller.
`timescale 1ns/1ps
`default_nettype none
module sram_host_checker
#(
	parameter int ADDR_WIDTH = 18,
	parameter int DATA_WIDTH = 16
)
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic req_ready,
	input wire logic retained,
	input wire logic [ADDR_WIDTH-1:0] sram_addr,
	input wire logic sram_select_low,
	input wire logic sram_select_high,
	input wire logic write_strobe_n,
	input wire logic output_strobe_n,
	input wire logic [DATA_WIDTH-1:0] data_out,
	input wire logic data_oe
);
default clocking @(posedge sys_clk); endclocking
default disable iff (reset);
wire on = !sram_select_low && sram_select_high;
sel_hold_a: assert property ($fell(write_strobe_n) |->
	(on && !write_strobe_n)[*6]) else $error("select dropped early");
addr_hold_a: assert property ($fell(write_strobe_n) |->
	$stable(sram_addr)[*6]) else $error("address moved in write");
data_hold_a: assert property ($fell(write_strobe_n) |->
	($past(data_oe) && data_oe && $stable(data_out))[*6])
	else $error("write data not held");
no_clash_a: assert property (data_oe |-> output_strobe_n)
	else $error("host drives while memory may drive");
write_end_a: assert property ($rose(write_strobe_n) |->
	!on && !data_oe) else $error("write end not clean");
min_active_a: assert property ($rose(on) |-> on[*7])
	else $error("access shorter than cycle time");
min_gap_a: assert property ($fell(on) |-> (!on)[*3])
	else $error("gap too short");
retain_off_a: assert property (retained |-> !on && !data_oe)
	else $error("memory selected in retention");
recover_a: assert property ($fell(retained) |-> (!req_ready)[*7])
	else $error("access too soon after retention");
cover property ($fell(write_strobe_n));
cover property ($rose(on) && write_strobe_n);
cover property ($fell(retained));
endmodule
`default_nettype wire

// *** dv/sram_model.sv ***
// Behavioural model of the asynchronous SRAM seen by the host.
`timescale 1ns/1ps
`default_nettype none
module sram_model
(
	input wire logic [17:0] sram_addr,
	input wire logic sram_select_low,
	input wire logic sram_select_high,
	input wire logic write_strobe_n,
	input wire logic output_strobe_n,
	input wire logic lower_lane_enable_n,
	input wire logic upper_lane_enable_n,
	input wire logic [15:0] din,
	output logic [15:0] q
);
logic [15:0] mem [0:262143];
logic [15:0] last = 16'h0000;
logic [15:0] nq;
wire act = !sram_select_low && sram_select_high &&
	!(lower_lane_enable_n && upper_lane_enable_n);
wire wr = act && !write_strobe_n;
wire rd = act && write_strobe_n && !output_strobe_n;
// Written data lands during the overlap, so it reads back unchanged.
always @*
begin
	if (wr && !lower_lane_enable_n)
		mem[sram_addr][7:0] = din[7:0];
	if (wr && !upper_lane_enable_n)
		mem[sram_addr][15:8] = din[15:8];
end
// Released lanes show the inverse of their last value, never a stale copy.
always @*
begin
	nq = ~last;
	if (rd && !lower_lane_enable_n)
		nq[7:0] = mem[sram_addr][7:0];
	if (rd && !upper_lane_enable_n)
		nq[15:8] = mem[sram_addr][15:8];
end
always @(nq)
begin
	if (rd && !lower_lane_enable_n)
		last[7:0] = nq[7:0];
	if (rd && !upper_lane_enable_n)
		last[15:8] = nq[15:8];
end
assign #10 q = nq;
endmodule
`default_nettype wire

// *** dv/sram_host_tb_top.sv ***
// Testbench of the SRAM host controller against the memory model.
`timescale 1ns/1ps
`include "sram_host_consts.svh"
`default_nettype none
module sram_host_tb_top;
logic sys_clk = 1'b0;
logic reset = 1'b1;
logic req_valid = 1'b0;
logic req_write = 1'b0;
logic [17:0] req_addr = 18'h00000;
logic [15:0] req_wdata = 16'h0000;
logic [1:0] req_lanes = 2'h0;
logic retain_req = 1'b0;
logic req_ready, rsp_valid, retained, sel_lo, sel_hi, we_n, oe_n;
logic lb_n, ub_n, data_oe;
logic [17:0] sram_addr;
logic [15:0] rsp_rdata, data_out, mem_q;
wire logic [15:0] data_in = data_oe ? data_out : mem_q;
int num_errors = 0;
int total_checks = 0;
sram_host dut_u (.sys_clk(sys_clk), .reset(reset), .req_valid(req_valid),
	.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
	.req_lanes(req_lanes), .retain_req(retain_req), .req_ready(req_ready),
	.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .retained(retained),
	.sram_addr(sram_addr), .sram_select_low(sel_lo),
	.sram_select_high(sel_hi), .write_strobe_n(we_n),
	.output_strobe_n(oe_n), .lower_lane_enable_n(lb_n),
	.upper_lane_enable_n(ub_n), .data_in(data_in), .data_out(data_out),
	.data_oe(data_oe));
sram_model mem_u (.sram_addr(sram_addr), .sram_select_low(sel_lo),
	.sram_select_high(sel_hi), .write_strobe_n(we_n),
	.output_strobe_n(oe_n), .lower_lane_enable_n(lb_n),
	.upper_lane_enable_n(ub_n), .din(data_out), .q(mem_q));
initial
begin
	forever #5 sys_clk = ~sys_clk;
end
task automatic chk(input string what, input logic [31:0] seen,
	input logic [31:0] exp);
	total_checks++;
	if (seen !== exp)
	begin
		num_errors++;
		$display("ERROR %s expected %h seen %h", what, exp, seen);
	end
endtask
task automatic wrap_up();
	if (num_errors == 0 && total_checks > 0)
		$display("SIMULATION PASSED");
	else
		$display("SIMULATION FAILED");
	$finish;
endtask
task automatic tick();
	@(posedge sys_clk);
	#1;
endtask
task automatic wait_hi(input bit on_retained);
	int n;
	for (n = 0; n < 40
		&& (on_retained ? retained : req_ready) !== 1'b1; n++)
		tick();
	if (n == 40)
	begin
		chk("wait", 0, 1);
		wrap_up();
	end
endtask
task automatic access(input logic w, input logic [17:0] a,
	input logic [15:0] d, input logic [1:0] ln);
	int n;
	wait_hi(1'b0);
	req_valid = 1'b1;
	req_write = w;
	req_addr = a;
	req_wdata = d;
	req_lanes = ln;
	tick();
	req_valid = 1'b0;
	for (n = 1; n < 40 && !w && rsp_valid !== 1'b1; n++)
		tick();
	// The read phase lasts its cycle time, then two synchroniser stages.
	if (!w)
		chk("rsp_latency", n - 1, `READ_CYCLES + 2);
	if (n == 40)
		wrap_up();
endtask
task automatic rd_chk(input logic [17:0] a, input logic [1:0] ln,
	input logic [15:0] exp);
	access(1'b0, a, 16'h0000, ln);
	chk("rsp_rdata", {16'h0000, rsp_rdata}, {16'h0000, exp});
endtask
task automatic full_word();
	access(1'b1, 18'h00010, 16'hA5C3, 2'h3);
	rd_chk(18'h00010, 2'h3, 16'hA5C3);
	access(1'b1, 18'h3FFFF, 16'h1234, 2'h0);
	rd_chk(18'h3FFFF, 2'h0, 16'h1234);
endtask
task automatic byte_lanes();
	access(1'b1, 18'h3FFFF, 16'hEEAB, 2'h1);
	rd_chk(18'h3FFFF, 2'h3, 16'h12AB);
	access(1'b1, 18'h3FFFF, 16'hCDEE, 2'h2);
	rd_chk(18'h3FFFF, 2'h1, 16'h00AB);
	rd_chk(18'h3FFFF, 2'h2, 16'hCD00);
endtask
task automatic retention();
	int n;
	retain_req = 1'b1;
	wait_hi(1'b1);
	req_valid = 1'b1;
	req_write = 1'b1;
	req_wdata = 16'h0000;
	req_lanes = 2'h3;
	req_addr = 18'h00010;
	repeat (5) tick();
	chk("req_ready", req_ready, 0);
	chk("sram_select_low", sel_lo, 1);
	req_valid = 1'b0;
	retain_req = 1'b0;
	for (n = 0; n < 40 && req_ready !== 1'b1; n++)
		tick();
	chk("recovery_wait", n >= `RECOVER_CYCLES && n < 40, 1);
	if (n == 40)
		wrap_up();
	rd_chk(18'h00010, 2'h3, 16'hA5C3);
endtask
initial
begin
	repeat (20) @(posedge sys_clk);
	#1;
	reset = 1'b0;
	full_word();
	byte_lanes();
	retention();
	wrap_up();
end
endmodule
bind sram_host sram_host_checker #(.ADDR_WIDTH(ADDR_WIDTH),
	.DATA_WIDTH(DATA_WIDTH)) chk_u (.sys_clk(sys_clk), .reset(reset),
	.req_ready(req_ready), .retained(retained), .sram_addr(sram_addr),
	.sram_select_low(sram_select_low), .sram_select_high(sram_select_high),
	.write_strobe_n(write_strobe_n), .output_strobe_n(output_strobe_n),
	.data_out(data_out), .data_oe(data_oe));
`default_nettype wire
